// File: common/pdh_defines.vh
// Constants for the power-down and pin-hold block
`ifndef PDH_DEFINES_VH
`define PDH_DEFINES_VH

`define PDH_N_IN 11
`define PDH_N_IO 10
`define PDH_N_SOP 4
`define PDH_PD_IDX 3
`define PDH_ZERO_IN 11'h000
`define PDH_ZERO_IO 10'h000
`define PDH_ZERO_TERM 84'h0
`define PDH_ZERO_SOP 4'h0
`define PDH_TERM_W 84
`define PDH_ONES_SOP 4'hF
`define PDH_OE_ALL_OFF 10'h000
`define PDH_CFG_RST 10'h000

`endif

// File: src/pdh_macrocell.v
// One output macrocell: register, polarity, output enable, freeze on power-down
`timescale 1ns/1ps
`include "pdh_defines.vh"

module pdh_macrocell (
  input wire ref_clk, // Device clock
  input wire srst, // Synchronous reset, active high
  input wire clk_en, // Clock enable
  input wire frozen, // Power-down in force
  input wire [`PDH_N_SOP-1:0] sum_terms, // OR-plane terms for this cell
  input wire oe_term, // Output enable product term
  input wire reg_mode, // Has no effect: output is registered with the same value at 1 or 0
  input wire invert, // Output polarity
  output reg q_reg, // Cell register state
  output reg out_reg, // Pin data presented
  output reg oe_reg // Pin driven
);

  wire sum_or;
  wire comb_val;
  reg q_next;
  reg out_next;
  reg oe_next;

  assign sum_or = |sum_terms;
  assign comb_val = sum_or ^ invert;

  always @*
  begin
    q_next = q_reg;
    out_next = out_reg;
    oe_next = oe_reg;
    if (!frozen) // R13
    begin
      q_next = sum_or;
      out_next = reg_mode ? (sum_or ^ invert) : comb_val;
      oe_next = oe_term;
    end
  end

  // Frozen cells keep whatever they hold, even an undefined value
  always @(posedge ref_clk)
  begin
    if (srst)
    begin
      q_reg <= 1'b0;
      out_reg <= 1'b0;
      oe_reg <= 1'b0;
    end
    else if (clk_en)
    begin
      q_reg <= q_next; // R04
      out_reg <= out_next; // R05 R06
      oe_reg <= oe_next; // R07
    end
  end

endmodule

// File: src/pdh_top.v
// Power-down control, pin keepers and a small logic array
// Operation
// R01 - Undriven inputs and I/O pins keep presenting their last driven level.
// R02 - Any active external driver overrides a held pin level at once.
// R03 - With option set, high power-down pin means power-down, low means normal.
// R04 - Entering power-down captures all outputs and internal states, held throughout.
// R05 - Registered and combinational outputs keep their values during power-down.
// R06 - An undetermined output at power-down entry stays exactly as it was.
// R07 - In power-down every input, clock and output enable is ignored.
// R08 - Pin hold latches stay active during power-down; no pin floats.
// R09 - One configuration fuse bit selects the power-down function of shared pin.
// R10 - With power-down enabled the shared pin does not feed the array.
// R11 - Shared pin macrocell still gives buried feedback and foldback terms.
// R12 - Without power-down option the shared pin is an ordinary array input.
// R13 - Pin low again resumes normal operation from the held states.
`timescale 1ns/1ps
`include "pdh_defines.vh"

module pdh_top (
  input wire ref_clk, // Device clock
  input wire srst, // Synchronous reset, active high
  input wire clk_en, // Clock enable, freezes all state when low
  input wire pd_fuse, // Power-down option fuse bit
  input wire [`PDH_N_IN-1:0] in_pin, // Dedicated input pins
  input wire [`PDH_N_IN-1:0] in_drv, // Input pin is driven from outside
  input wire [`PDH_N_IO-1:0] io_in, // I/O pin level from outside
  input wire [`PDH_N_IO-1:0] io_drv, // I/O pin is driven from outside
  input wire [`PDH_TERM_W-1:0] and_plane, // Product-term select pattern
  input wire [`PDH_N_IO-1:0] cell_regmode, // Per-cell registered mode
  input wire [`PDH_N_IO-1:0] cell_invert, // Per-cell output polarity
  output reg [`PDH_N_IO-1:0] io_out, // I/O pin output data
  output reg [`PDH_N_IO-1:0] io_oe, // I/O pin output enable
  output reg [`PDH_N_IN-1:0] in_keep, // Held level of dedicated inputs
  output reg [`PDH_N_IO-1:0] io_keep, // Held level of I/O pins
  output reg pd_active // Device is in power-down
);

  // ==========================================================
  // Fuse and power-down decode
  // ==========================================================
  // Fuse taken at reset release so it cannot change mid-operation
  reg fuse_reg;
  reg fuse_seen_reg;
  wire shared_pin;
  wire frozen;

  assign shared_pin = in_drv[`PDH_PD_IDX] ? in_pin[`PDH_PD_IDX]
                                          : in_keep[`PDH_PD_IDX];
  assign frozen = fuse_reg & shared_pin; // R03 R09

  always @(posedge ref_clk)
  begin
    if (srst)
    begin
      fuse_reg <= 1'b0;
      fuse_seen_reg <= 1'b0;
    end
    else if (clk_en && !fuse_seen_reg)
    begin
      fuse_reg <= pd_fuse; // R09
      fuse_seen_reg <= 1'b1;
    end
  end

  // ==========================================================
  // Pin keepers
  // ==========================================================
  // Keepers are bus-hold cells: driven level wins, else last level
  function [`PDH_N_IO-1:0] keep_io;
    input [`PDH_N_IO-1:0] lvl;
    input [`PDH_N_IO-1:0] drv;
    input [`PDH_N_IO-1:0] held;
    begin
      keep_io = (lvl & drv) | (held & ~drv);
    end
  endfunction

  function [`PDH_N_IN-1:0] keep_in;
    input [`PDH_N_IN-1:0] lvl;
    input [`PDH_N_IN-1:0] drv;
    input [`PDH_N_IN-1:0] held;
    begin
      keep_in = (lvl & drv) | (held & ~drv);
    end
  endfunction

  wire [`PDH_N_IN-1:0] in_now;
  wire [`PDH_N_IO-1:0] io_ext;
  wire [`PDH_N_IO-1:0] io_drv_any;
  wire [`PDH_N_IO-1:0] io_lvl;
  wire [`PDH_N_IO-1:0] io_now;

  assign in_now = keep_in(in_pin, in_drv, in_keep); // R01 R02
  // Own driver counts as a driver on the pin
  assign io_drv_any = io_drv | io_oe;
  assign io_lvl = (io_in & io_drv) | (io_out & io_oe & ~io_drv);
  assign io_ext = keep_io(io_lvl, io_drv_any, io_keep); // R01 R02
  assign io_now = io_ext;

  always @(posedge ref_clk)
  begin
    if (srst)
    begin
      in_keep <= `PDH_ZERO_IN;
      io_keep <= `PDH_ZERO_IO;
    end
    else if (clk_en)
    begin
      // Keepers run in power-down too, so pins never float
      in_keep <= in_now; // R08
      io_keep <= io_now; // R08
    end
  end

  // ==========================================================
  // Array inputs with power-down blocking
  // ==========================================================
  reg [`PDH_N_IN-1:0] arr_in_reg;
  reg [`PDH_N_IN-1:0] arr_in_next;
  wire [`PDH_N_IO-1:0] fb;

  always @*
  begin
    arr_in_next = in_now;
    if (fuse_reg)
      arr_in_next[`PDH_PD_IDX] = 1'b0; // R10
    else
      arr_in_next[`PDH_PD_IDX] = in_now[`PDH_PD_IDX]; // R12
    if (frozen)
      arr_in_next = arr_in_reg; // R07
  end

  always @(posedge ref_clk)
  begin
    if (srst)
      arr_in_reg <= `PDH_ZERO_IN;
    else if (clk_en)
      arr_in_reg <= arr_in_next;
  end

  // ==========================================================
  // Product terms and macrocells
  // ==========================================================
  // Cut-down array: each cell ORs four terms; term = one array signal
  // picked or gated by plane bits, a crude stand-in that keeps the freeze path honest
  wire [`PDH_N_IN+`PDH_N_IO-1:0] arr_sig;
  wire [`PDH_N_IO-1:0] q_w;
  wire [`PDH_N_IO-1:0] out_w;
  wire [`PDH_N_IO-1:0] oe_w;
  // Buried feedback keeps working even on the shared-pin cell
  assign arr_sig = {fb, arr_in_reg}; // R11
  assign fb = q_w;

  genvar gi;
  generate
    for (gi = 0; gi < `PDH_N_IO; gi = gi + 1)
    begin : g_cell
      wire [`PDH_N_SOP-1:0] terms;
      wire [7:0] sel;
      assign sel = and_plane[gi*8 +: 8];
      assign terms[0] = arr_sig[sel[4:0] % (`PDH_N_IN+`PDH_N_IO)];
      assign terms[1] = arr_sig[(gi+`PDH_N_IN) % (`PDH_N_IN+`PDH_N_IO)]
                        & sel[5];
      assign terms[2] = arr_in_reg[gi % `PDH_N_IN] & sel[6];
      assign terms[3] = ~fb[gi] & sel[7];
      pdh_macrocell u_cell (
        .ref_clk(ref_clk),
        .srst(srst),
        .clk_en(clk_en),
        .frozen(frozen),
        .sum_terms(terms),
        .oe_term(and_plane[`PDH_N_IO*8 + (gi % 4)]),
        .reg_mode(cell_regmode[gi]),
        .invert(cell_invert[gi]),
        .q_reg(q_w[gi]),
        .out_reg(out_w[gi]),
        .oe_reg(oe_w[gi])
      );
    end
  endgenerate

  // ==========================================================
  // Output stage
  // ==========================================================
  always @(posedge ref_clk)
  begin
    if (srst)
    begin
      io_out <= `PDH_ZERO_IO;
      io_oe <= `PDH_OE_ALL_OFF;
      pd_active <= 1'b0;
    end
    else if (clk_en)
    begin
      io_out <= out_w; // R05
      io_oe <= oe_w; // R05
      pd_active <= frozen; // R03
    end
  end

endmodule

// File: tb/pdh_sys_model.sv
// System-side model that drives the device pins
`timescale 1ns/1ps
`include "pdh_defines.vh"
module pdh_sys_model (
  input wire ref_clk, // Clock
  input wire [`PDH_N_IN-1:0] in_val, // Input level wanted
  input wire [`PDH_N_IN-1:0] in_en, // Input driven
  input wire [`PDH_N_IO-1:0] io_val, // I/O level wanted
  input wire [`PDH_N_IO-1:0] io_en, // I/O driven
  output reg [`PDH_N_IN-1:0] in_pin, // Input pin level
  output reg [`PDH_N_IN-1:0] in_drv, // Input driven flag
  output reg [`PDH_N_IO-1:0] io_in, // I/O pin level
  output reg [`PDH_N_IO-1:0] io_drv // I/O driven flag
);
  initial
  begin
    in_pin = `PDH_ZERO_IN;
    in_drv = `PDH_ZERO_IN;
    io_in = `PDH_ZERO_IO;
    io_drv = `PDH_ZERO_IO;
  end
  // Released lines toggle each cycle so a dead keeper shows
  always @(posedge ref_clk)
  begin
    in_drv <= in_en;
    io_drv <= io_en;
    in_pin <= (in_en & in_val) | (~in_en & ~in_pin);
    io_in <= (io_en & io_val) | (~io_en & ~io_in);
  end
endmodule

// File: tb/pdh_checker.sv
// Checker for keeper and power-down relations
`timescale 1ns/1ps
`include "pdh_defines.vh"
module pdh_checker (
  input wire ref_clk, // Clock
  input wire srst, // Reset
  input wire clk_en, // Clock enable
  input wire pd_fuse, // Option fuse
  input wire [`PDH_N_IN-1:0] in_pin, // Input levels
  input wire [`PDH_N_IN-1:0] in_drv, // Input driven
  input wire [`PDH_N_IO-1:0] io_in, // I/O levels
  input wire [`PDH_N_IO-1:0] io_drv, // I/O driven
  input wire [`PDH_N_IO-1:0] io_out, // Pin data
  input wire [`PDH_N_IO-1:0] io_oe, // Pin enable
  input wire [`PDH_N_IN-1:0] in_keep, // Input keepers
  input wire [`PDH_N_IO-1:0] io_keep, // I/O keepers
  input wire pd_active // Power-down
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (srst);
  property p_rst;
    $fell(srst) |-> !pd_active && io_oe == `PDH_OE_ALL_OFF;
  endproperty
  a_rst: assert property (p_rst) else $error("state after reset");
  property p_in_keep;
    clk_en |=> in_keep == (($past(in_drv) & $past(in_pin))
      | (~$past(in_drv) & $past(in_keep)));
  endproperty
  a_in_keep: assert property (p_in_keep) else $error("in keep");
  property p_io_keep;
    clk_en |=> (io_keep & $past(io_drv)) == ($past(io_in) & $past(io_drv));
  endproperty
  a_io_keep: assert property (p_io_keep) else $error("io keep");
  property p_out_hold;
    pd_active && $past(pd_active) |-> $stable(io_out);
  endproperty
  a_out_hold: assert property (p_out_hold) else $error("out moved");
  property p_oe_hold;
    pd_active && $past(pd_active) |-> $stable(io_oe);
  endproperty
  a_oe_hold: assert property (p_oe_hold) else $error("oe moved");
  property p_fuse;
    $rose(pd_active) |-> pd_fuse;
  endproperty
  a_fuse: assert property (p_fuse) else $error("pd without fuse");
  property p_enter;
    (pd_fuse && clk_en && in_drv[3] && in_pin[3]) [*4] |-> pd_active;
  endproperty
  a_enter: assert property (p_enter) else $error("no pd entry");
  property p_leave;
    (clk_en && in_drv[3] && !in_pin[3]) [*3] |-> !pd_active;
  endproperty
  a_leave: assert property (p_leave) else $error("no pd exit");
  c_enter: cover property ($rose(pd_active));
  c_exit: cover property ($fell(pd_active));
  c_kept: cover property (!in_drv[0] && in_keep[0]);
endmodule
bind pdh_top pdh_checker i_pdh_checker (.ref_clk(ref_clk), .srst(srst),
  .clk_en(clk_en), .pd_fuse(pd_fuse), .in_pin(in_pin), .in_drv(in_drv),
  .io_in(io_in), .io_drv(io_drv), .io_out(io_out), .io_oe(io_oe),
  .in_keep(in_keep), .io_keep(io_keep), .pd_active(pd_active));

// File: tb/pdh_top_tb.sv
// Testbench for keepers, power-down entry, freeze and release
`timescale 1ns/1ps
`include "pdh_defines.vh"
module pdh_top_tb;
  logic ref_clk = 1'b0;
  logic srst = 1'b1;
  logic clk_en = 1'b1;
  logic pd_fuse = 1'b1;
  logic [10:0] in_val = 11'h000, in_en = 11'h7FF, in_pin, in_drv, in_keep;
  logic [9:0] io_val = 10'h000, io_en = 10'h000, io_in, io_drv, io_keep;
  logic [9:0] rmode = 10'h000, inv = 10'h000, io_out, io_oe, so, se;
  logic [83:0] plane = `PDH_ZERO_TERM;
  logic pd_active;
  integer mismatches = 0, comparisons = 0;
  always #20 ref_clk = ~ref_clk;
  pdh_sys_model i_pdh_sys_model (.ref_clk(ref_clk), .in_val(in_val),
    .in_en(in_en), .io_val(io_val), .io_en(io_en), .in_pin(in_pin),
    .in_drv(in_drv), .io_in(io_in), .io_drv(io_drv));
  pdh_top i_pdh_top (.ref_clk(ref_clk), .srst(srst), .clk_en(clk_en),
    .pd_fuse(pd_fuse), .in_pin(in_pin), .in_drv(in_drv), .io_in(io_in),
    .io_drv(io_drv), .and_plane(plane), .cell_regmode(rmode),
    .cell_invert(inv), .io_out(io_out), .io_oe(io_oe),
    .in_keep(in_keep), .io_keep(io_keep), .pd_active(pd_active));
  task wt(input integer n);
    repeat (n) @(posedge ref_clk);
    @(negedge ref_clk);
  endtask
  task chk(input logic [10:0] g, input logic [10:0] e);
    comparisons++;
    if (g !== e)
    begin
      mismatches++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task wpd(input logic v);
    integer k;
    k = 0;
    while (pd_active !== v && k < 6)
    begin
      wt(1);
      k++;
    end
    chk({10'h000, pd_active}, {10'h000, v});
  endtask
  task do_reset;
    @(posedge ref_clk);
    srst <= 1'b1;
    repeat (8) @(posedge ref_clk);
    srst <= 1'b0;
    wt(2);
  endtask
  task t_keep;
    @(posedge ref_clk);
    in_val <= 11'h5A5;
    io_val <= 10'h2B3;
    io_en <= 10'h3FF;
    wt(3);
    chk({1'b0, io_keep}, 11'h2B3);
    @(posedge ref_clk);
    in_en <= 11'h008;
    io_en <= 10'h000;
    wt(4);
    chk(in_keep, 11'h5A5);
    $display("t_keep done");
  endtask
  task t_pd;
    @(posedge ref_clk);
    in_en <= 11'h7FF;
    plane <= {84{1'b1}};
    wt(5);
    @(posedge ref_clk);
    in_val <= 11'h5AD;
    wpd(1'b1);
    so = io_out;
    se = io_oe;
    @(posedge ref_clk);
    plane <= `PDH_ZERO_TERM;
    inv <= 10'h3FF;
    rmode <= 10'h3FF;
    in_val <= 11'h7FF;
    clk_en <= 1'b0;
    wt(3);
    @(posedge ref_clk);
    clk_en <= 1'b1;
    wt(3);
    chk({1'b0, io_out}, {1'b0, so});
    chk({1'b0, io_oe}, {1'b0, se});
    chk(in_keep, 11'h7FF);
    @(posedge ref_clk);
    in_val <= 11'h7F7;
    wpd(1'b0);
    $display("t_pd done");
  endtask
  task t_nofuse;
    @(posedge ref_clk);
    pd_fuse <= 1'b0;
    do_reset;
    @(posedge ref_clk);
    in_val <= 11'h008;
    wt(6);
    chk({10'h000, pd_active}, 11'h000);
    // Cell 0 reads the shared pin; polarity left inverted from t_pd
    @(posedge ref_clk);
    plane <= (84'h1 << 80) | 84'h3;
    wt(4);
    chk({10'h000, io_out[0]}, 11'h000);
    chk({10'h000, io_oe[0]}, 11'h001);
    @(posedge ref_clk);
    in_val <= 11'h000;
    wt(6);
    chk({10'h000, io_out[0]}, 11'h001);
    $display("t_nofuse done");
  endtask
  task tally_and_finish;
    $display("Counts: %0d compared, %0d wrong", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  initial
  begin
    #(40 * 2000);
    mismatches++;
    tally_and_finish;
  end
  initial
  begin
    do_reset;
    t_keep;
    t_pd;
    t_nofuse;
    tally_and_finish;
  end
endmodule
